// file: core/pcx_pkg.sv
package pcx_pkg;

   // ************************************************************
   // Sizes
   // ************************************************************
   localparam int PCX_NUM_PINS = 20;   // P0.0 .. P2.3, pin index = 8*port + bit
   localparam int PCX_NUM_SIG  = 21;   // Routable peripheral signals
   localparam int PCX_SIG_W    = 5;
   localparam int PCX_P2_PINS  = 4;    // Assignable pins of port 2

   // ************************************************************
   // Peripheral signal codes, in descending priority
   // ************************************************************
   typedef logic [PCX_SIG_W-1:0] pcx_sig_t;
   localparam pcx_sig_t SIG_TX    = 5'h00;
   localparam pcx_sig_t SIG_RX    = 5'h01;
   localparam pcx_sig_t SIG_SCK   = 5'h02;
   localparam pcx_sig_t SIG_MISO  = 5'h03;
   localparam pcx_sig_t SIG_MOSI  = 5'h04;
   localparam pcx_sig_t SIG_SEL   = 5'h05;
   localparam pcx_sig_t SIG_SDA   = 5'h06;
   localparam pcx_sig_t SIG_SCL   = 5'h07;
   localparam pcx_sig_t SIG_CP0   = 5'h08;
   localparam pcx_sig_t SIG_CMP0A = 5'h09;
   localparam pcx_sig_t SIG_CP1   = 5'h0A;
   localparam pcx_sig_t SIG_CP1A  = 5'h0B;
   localparam pcx_sig_t SIG_SYSCK = 5'h0C;
   localparam pcx_sig_t SIG_CHAN0 = 5'h0D;
   localparam pcx_sig_t SIG_EXTC  = 5'h12;
   localparam pcx_sig_t SIG_T0    = 5'h13;
   localparam pcx_sig_t SIG_T1    = 5'h14;
   localparam pcx_sig_t SIG_NONE  = 5'h1F;  // Pin left as port I/O

   // ************************************************************
   // Fixed UART pins
   // ************************************************************
   localparam int PCX_TX_PIN = 4;
   localparam int PCX_RX_PIN = 5;

   // ************************************************************
   // route_select_a bit positions
   // ************************************************************
   localparam int RA_UART  = 0;
   localparam int RA_SPI   = 1;
   localparam int RA_SMB   = 2;
   localparam int RA_SYSCK = 3;
   localparam int RA_CP0   = 4;
   localparam int RA_CMP0A = 5;
   localparam int RA_CP1   = 6;
   localparam int RA_CP1A  = 7;

   // ************************************************************
   // route_select_b bit positions
   // ************************************************************
   localparam int RB_CEX_LSB = 0;
   localparam int RB_CEX_MSB = 2;
   localparam int RB_EXTC    = 3;
   localparam int RB_T0      = 4;
   localparam int RB_T1      = 5;
   localparam int RB_XBAR_EN = 6;

   // ************************************************************
   // Field codes and reset values
   // ************************************************************
   localparam logic [2:0] PCX_CEX_MAX     = 3'h5;   // Codes above are reserved
   localparam logic [1:0] PCX_SEL_3WIRE   = 2'h0;   // Select line not pinned out
   localparam logic [7:0] PCX_XTAL_SKIP   = 8'h0C;  // Crystal pins skipped
   localparam logic       PCX_MODE_PP     = 1'b1;   // Output mode bit: push-pull
   localparam logic [PCX_NUM_PINS-1:0] PCX_LATCH_RST = 20'hFFFFF;

   // ************************************************************
   // Carriers
   // ************************************************************
   typedef struct packed {
      logic [7:0]              route_select_a;
      logic [7:0]              route_select_b;
      logic [7:0]              port0_skip_mask;
      logic [7:0]              port1_skip_mask;
      logic [PCX_P2_PINS-1:0]  port2_skip_mask;
      logic [PCX_NUM_PINS-1:0] port_output_mode;
      logic [1:0]              spi_select_mode_field;
   } pcx_cfg_t;

   typedef struct packed {
      logic [PCX_NUM_SIG-1:0] out;    // Value each peripheral signal would drive
      logic [PCX_NUM_SIG-1:0] drive;  // Peripheral wants to drive the signal
   } pcx_periph_t;

   typedef struct packed {
      logic [PCX_NUM_PINS-1:0]                pin_out;
      logic [PCX_NUM_PINS-1:0]                pin_oe;
      logic [PCX_NUM_SIG-1:0]                 sig_in;
      logic [PCX_NUM_PINS-1:0]                port_read;
      logic [PCX_NUM_PINS-1:0][PCX_SIG_W-1:0] pin_sig;
      logic [PCX_NUM_PINS-1:0]                skip_q;
   } pcx_state_t;

endpackage : pcx_pkg

// file: core/pcx_crossbar.sv
// Summary of operation
// RULE1: Only pins P0.0 to P2.3 take peripheral signals; others never routed.
// RULE2: Each enabled signal, by priority, takes lowest free unskipped pin.
// RULE3: Enabled UART transmit sits on P0.4, receive on P0.5, always.
// RULE4: Pins already given to higher-priority signals are passed over.
// RULE5: Skipped pins count as taken; search moves to the next free pin.
// RULE6: Bit n of port-0 skip mask is pin P0.n; 0x0C skips P0.2, P0.3.
// RULE7: Software skips pins used by dedicated analog or clock functions.
// RULE8: Decoder never places dedicated functions; only skip bits reserve them.
// RULE9: Serial bus enable places data and clock together on the next two free pins.
// RULE10: UART enable claims transmit and receive together, never one alone.
// RULE11: Unassigned unskipped pins stay port I/O, contiguous after assigned ones.
// RULE12: SPI select takes a pin only in four-wire mode.
// RULE13: Port reads always return pin levels, routed or not.
// RULE14: Per-pin output-mode bit selects push-pull or open-drain driver.
// RULE15: With decoder disabled all pins are port I/O in input mode.
// RULE16: Counter routing code 1..5 routes that many channels; 6, 7 reserved.
// RULE17: Software loads routing selections before relying on pin assignment.
// RULE18: Fixed priority: UART, SPI, serial bus, comparators, clock, channels, timers.
// RULE19: Skip masks are 8, 8 and 4 bits wide for ports 0, 1, 2.
module pcx_crossbar (
   // Clock and reset
   input  wire logic                                      clk,
   input  wire logic                                      rstn,
   input  wire logic                                      ce,
   // Configuration
   input  wire pcx_pkg::pcx_cfg_t                         cfg,
   input  wire logic [pcx_pkg::PCX_NUM_PINS-1:0]          port_latch,
   // Peripheral side
   input  wire pcx_pkg::pcx_periph_t                      periph,
   output logic [pcx_pkg::PCX_NUM_SIG-1:0]                periph_in,
   // Pin side
   input  wire logic [pcx_pkg::PCX_NUM_PINS-1:0]          pin_in,
   output logic [pcx_pkg::PCX_NUM_PINS-1:0]               pin_out,
   output logic [pcx_pkg::PCX_NUM_PINS-1:0]               pin_oe,
   // Status
   output logic [pcx_pkg::PCX_NUM_PINS-1:0]               port_read,
   output logic [pcx_pkg::PCX_NUM_PINS-1:0][pcx_pkg::PCX_SIG_W-1:0] pin_signal
);
   import pcx_pkg::*;

   // ************************************************************
   // State
   // ************************************************************
   pcx_state_t st_ff;
   pcx_state_t nxt_st;

   logic [PCX_NUM_SIG-1:0]  sig_en;
   logic [PCX_NUM_PINS-1:0] taken;
   logic [PCX_NUM_PINS-1:0] skip_all;
   logic [PCX_NUM_PINS-1:0][PCX_SIG_W-1:0] sel;
   logic                    xbar_en;
   logic                    found;
   logic                    drv;
   logic                    val;
   logic                    open_drain;

   // Whole skip map; port-2 mask only covers its assignable pins
   assign skip_all = {cfg.port2_skip_mask, cfg.port1_skip_mask, cfg.port0_skip_mask}; // RULE6 RULE19
   assign xbar_en  = cfg.route_select_b[RB_XBAR_EN];

   // Enabled signals; reserved channel codes route nothing
   always_comb
   begin
      logic [2:0] cex_n;
      cex_n = cfg.route_select_b[RB_CEX_MSB:RB_CEX_LSB];
      sig_en = '0;
      sig_en[SIG_TX]    = cfg.route_select_a[RA_UART];   // RULE10
      sig_en[SIG_RX]    = cfg.route_select_a[RA_UART];   // RULE10
      sig_en[SIG_SCK]   = cfg.route_select_a[RA_SPI];
      sig_en[SIG_MISO]  = cfg.route_select_a[RA_SPI];
      sig_en[SIG_MOSI]  = cfg.route_select_a[RA_SPI];
      sig_en[SIG_SEL]   = cfg.route_select_a[RA_SPI]
                          && (cfg.spi_select_mode_field != PCX_SEL_3WIRE); // RULE12
      sig_en[SIG_SDA]   = cfg.route_select_a[RA_SMB];    // RULE9
      sig_en[SIG_SCL]   = cfg.route_select_a[RA_SMB];    // RULE9
      sig_en[SIG_CP0]   = cfg.route_select_a[RA_CP0];
      sig_en[SIG_CMP0A] = cfg.route_select_a[RA_CMP0A];
      sig_en[SIG_CP1]   = cfg.route_select_a[RA_CP1];
      sig_en[SIG_CP1A]  = cfg.route_select_a[RA_CP1A];
      sig_en[SIG_SYSCK] = cfg.route_select_a[RA_SYSCK];
      for (int k = 0; k < int'(PCX_CEX_MAX); k++)
      begin
         sig_en[int'(SIG_CHAN0) + k] = (cex_n <= PCX_CEX_MAX) && (int'(cex_n) > k); // RULE16
      end
      sig_en[SIG_EXTC]  = cfg.route_select_b[RB_EXTC];
      sig_en[SIG_T0]    = cfg.route_select_b[RB_T0];
      sig_en[SIG_T1]    = cfg.route_select_b[RB_T1];
   end

   // ************************************************************
   // Priority decode and pin drivers
   // ************************************************************
   // Recomputed every cycle, so a change of selections takes effect on the
   // next edge; software must still finish its setup first since partial
   // setups route pins too.
   always_comb
   begin
      nxt_st = st_ff;
      taken  = skip_all;                                  // RULE5 RULE8
      sel    = {PCX_NUM_PINS{SIG_NONE}};
      found  = 1'b0;
      drv    = 1'b0;
      val    = 1'b0;
      open_drain = 1'b0;
      if (xbar_en)
      begin
         // UART is fixed and wins over skip bits
         if (sig_en[SIG_TX])
         begin
            sel[PCX_TX_PIN]   = SIG_TX;                   // RULE3 RULE10
            sel[PCX_RX_PIN]   = SIG_RX;                   // RULE3 RULE10
            taken[PCX_TX_PIN] = 1'b1;
            taken[PCX_RX_PIN] = 1'b1;
         end
         // Remaining signals in priority order, lowest free pin first
         for (int s = int'(SIG_SCK); s < PCX_NUM_SIG; s++) // RULE18
         begin
            found = 1'b0;
            if (sig_en[s])
            begin
               for (int p = 0; p < PCX_NUM_PINS; p++)     // RULE1
               begin
                  if (!found && !taken[p])                // RULE2 RULE4 RULE5
                  begin
                     sel[p]   = pcx_sig_t'(s);
                     taken[p] = 1'b1;
                     found    = 1'b1;
                  end
               end
            end
         end
      end
      nxt_st.sig_in = '1;
      for (int p = 0; p < PCX_NUM_PINS; p++)
      begin
         if (sel[p] != SIG_NONE)
         begin
            val = periph.out[sel[p]];
            drv = periph.drive[sel[p]];
            nxt_st.sig_in[sel[p]] = pin_in[p];
         end
         else
         begin
            val = port_latch[p];                          // RULE11
            drv = 1'b1;
         end
         // Serial bus lines are open-drain whatever the mode bit says
         open_drain = (cfg.port_output_mode[p] != PCX_MODE_PP)
                      || (sel[p] == SIG_SDA) || (sel[p] == SIG_SCL); // RULE14
         nxt_st.pin_out[p] = val;
         nxt_st.pin_oe[p]  = xbar_en && drv && (!open_drain || !val);  // RULE14 RULE15
      end
      nxt_st.port_read = pin_in;                          // RULE13
      nxt_st.pin_sig   = sel;
      nxt_st.skip_q    = skip_all;
   end

   // Registered state, frozen while the clock enable is low
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         st_ff.pin_out   <= PCX_LATCH_RST;
         st_ff.pin_oe    <= '0;
         st_ff.sig_in    <= '1;
         st_ff.port_read <= '0;
         st_ff.pin_sig   <= {PCX_NUM_PINS{SIG_NONE}};
         st_ff.skip_q    <= '0;
      end
      else if (ce)
      begin
         st_ff <= nxt_st;
      end
   end

   assign pin_out    = st_ff.pin_out;
   assign pin_oe     = st_ff.pin_oe;
   assign periph_in  = st_ff.sig_in;
   assign port_read  = st_ff.port_read;
   assign pin_signal = st_ff.pin_sig;

   // ************************************************************
   // Checks
   // ************************************************************
   // Helper view of the registered routing
   logic [PCX_NUM_SIG-1:0] seen;
   logic                   gpio_gap;
   logic                   od_bad;
   logic                   gpio_hit;
   logic                   skip_hit;
   always_comb
   begin
      seen     = '0;
      gpio_gap = 1'b0;
      od_bad   = 1'b0;
      gpio_hit = 1'b0;
      skip_hit = 1'b0;
      for (int p = 0; p < PCX_NUM_PINS; p++)
      begin
         if (st_ff.pin_sig[p] != SIG_NONE)
         begin
            seen[st_ff.pin_sig[p]] = 1'b1;
            if (gpio_hit && st_ff.pin_sig[p] != SIG_TX && st_ff.pin_sig[p] != SIG_RX)
            begin
               gpio_gap = 1'b1;
            end
         end
         else if (!st_ff.skip_q[p])
         begin
            gpio_hit = 1'b1;
         end
         if ((st_ff.pin_sig[p] == SIG_SDA || st_ff.pin_sig[p] == SIG_SCL)
             && st_ff.pin_oe[p] && st_ff.pin_out[p])
         begin
            od_bad = 1'b1;
         end
         // Only the fixed UART pair may sit on a skipped pin
         if (st_ff.skip_q[p] && st_ff.pin_sig[p] != SIG_NONE
             && st_ff.pin_sig[p] != SIG_TX && st_ff.pin_sig[p] != SIG_RX)
         begin
            skip_hit = 1'b1;
         end
      end
   end

   property p_disabled_input;
      @(posedge clk) disable iff (!rstn)
      ce && !xbar_en |=> (pin_oe == '0) && (seen == '0);
   endproperty
   a_disabled_input: assert property (p_disabled_input) else $error("pin driven"); // RULE15

   property p_uart_fixed;
      @(posedge clk) disable iff (!rstn)
      ce && xbar_en && cfg.route_select_a[RA_UART]
      |=> pin_signal[PCX_TX_PIN] == SIG_TX && pin_signal[PCX_RX_PIN] == SIG_RX;
   endproperty
   a_uart_fixed: assert property (p_uart_fixed) else $error("uart pins moved"); // RULE3

   property p_uart_pair;
      @(posedge clk) disable iff (!rstn)
      ce && !cfg.route_select_a[RA_UART] |=> !seen[SIG_TX] && !seen[SIG_RX];
   endproperty
   a_uart_pair: assert property (p_uart_pair) else $error("uart line routed"); // RULE10

   property p_read_pins;
      @(posedge clk) disable iff (!rstn)
      ce |=> port_read == $past(pin_in);
   endproperty
   a_read_pins: assert property (p_read_pins) else $error("port read wrong"); // RULE13

   property p_lowest_pin;
      @(posedge clk) disable iff (!rstn)
      ce && xbar_en && cfg.route_select_a[RA_SPI] && !cfg.route_select_a[RA_UART]
      && skip_all == '0 |=> pin_signal[0] == SIG_SCK;
   endproperty
   a_lowest_pin: assert property (p_lowest_pin) else $error("first pin wrong"); // RULE2

   property p_priority;
      @(posedge clk) disable iff (!rstn)
      ce && xbar_en && cfg.route_select_a[RA_SPI] && cfg.route_select_a[RA_SMB]
      && !cfg.route_select_a[RA_UART] && cfg.spi_select_mode_field == PCX_SEL_3WIRE
      && skip_all == '0 |=> pin_signal[3] == SIG_SDA && pin_signal[4] == SIG_SCL;
   endproperty
   a_priority: assert property (p_priority) else $error("priority order wrong"); // RULE18

   property p_xtal_skip;
      @(posedge clk) disable iff (!rstn)
      ce && xbar_en && cfg.route_select_a[RA_SPI] && !cfg.route_select_a[RA_UART]
      && cfg.port0_skip_mask == PCX_XTAL_SKIP
      |=> pin_signal[0] == SIG_SCK && pin_signal[1] == SIG_MISO
          && pin_signal[4] == SIG_MOSI;
   endproperty
   a_xtal_skip: assert property (p_xtal_skip) else $error("skip mask ignored"); // RULE6

   property p_skip_free;
      @(posedge clk) disable iff (!rstn)
      ce |=> !gpio_gap;
   endproperty
   a_skip_free: assert property (p_skip_free) else $error("gap in routing"); // RULE11

   property p_skip_kept;
      @(posedge clk) disable iff (!rstn)
      ce |=> !skip_hit;
   endproperty
   a_skip_kept: assert property (p_skip_kept) else $error("skip ignored"); // RULE5

   property p_sel_3wire;
      @(posedge clk) disable iff (!rstn)
      ce && cfg.spi_select_mode_field == PCX_SEL_3WIRE |=> !seen[SIG_SEL];
   endproperty
   a_sel_3wire: assert property (p_sel_3wire) else $error("select pinned out"); // RULE12

   property p_smb_pair;
      @(posedge clk) disable iff (!rstn)
      ce && xbar_en && cfg.route_select_a[RA_SMB] && skip_all == '0
      |=> seen[SIG_SDA] && seen[SIG_SCL] && !od_bad;
   endproperty
   a_smb_pair: assert property (p_smb_pair) else $error("serial bus split"); // RULE9

   property p_cex_reserved;
      @(posedge clk) disable iff (!rstn)
      ce && cfg.route_select_b[RB_CEX_MSB:RB_CEX_LSB] > PCX_CEX_MAX |=> !seen[SIG_CHAN0];
   endproperty
   a_cex_reserved: assert property (p_cex_reserved) else $error("reserved code routed"); // RULE16

endmodule : pcx_crossbar

// file: verif/pcx_pin_model.sv
module pcx_pin_model (
   // Device pin drivers
   input  wire logic [pcx_pkg::PCX_NUM_PINS-1:0] pin_out,
   input  wire logic [pcx_pkg::PCX_NUM_PINS-1:0] pin_oe,
   // Board side level of released pins
   input  wire logic [pcx_pkg::PCX_NUM_PINS-1:0] ext_level,
   // Level seen back at the device
   output logic      [pcx_pkg::PCX_NUM_PINS-1:0] pin_in
);
   timeunit 1ns;
   timeprecision 1ps;
   import pcx_pkg::*;

   // ************************************************************
   // Pin resolution
   // ************************************************************
   // Released pins show a board level the bench reseeds often, so a
   // stale driven value cannot pass for a fresh one
   always_comb
   begin
      for (int i = 0; i < PCX_NUM_PINS; i++)
      begin
         pin_in[i] = pin_oe[i] ? pin_out[i] : ext_level[i];
      end
   end
endmodule : pcx_pin_model

// file: verif/priority_pin_crossbar_test.sv
module priority_pin_crossbar_test;
   timeunit 1ns;
   timeprecision 1ps;
   import pcx_pkg::*;

   // ************************************************************
   // Signals and bookkeeping
   // ************************************************************
   typedef struct packed {
      logic [PCX_NUM_PINS-1:0][PCX_SIG_W-1:0] sig;
      logic [PCX_NUM_PINS-1:0]                oe;
      logic [PCX_NUM_PINS-1:0]                out;
      logic [PCX_NUM_SIG-1:0]                 per;
      logic [PCX_NUM_PINS-1:0]                rd;
      logic [31:0]                            due;
   } pcx_exp_t;
   localparam int LIMIT = 5000;
   logic                                   clk;
   logic                                   rstn;
   logic                                   ce;
   pcx_cfg_t                               cfg;
   pcx_periph_t                            periph;
   logic [PCX_NUM_PINS-1:0]                port_latch, pin_in, pin_out, pin_oe;
   logic [PCX_NUM_PINS-1:0]                port_read, ext_level;
   logic [PCX_NUM_SIG-1:0]                 periph_in;
   logic [PCX_NUM_PINS-1:0][PCX_SIG_W-1:0] pin_signal;
   pcx_exp_t                               q[$];
   pcx_exp_t                               prev;
   int                                     errors, checked, cyc;

   pcx_crossbar uut (
      .clk(clk), .rstn(rstn), .ce(ce), .cfg(cfg), .port_latch(port_latch),
      .periph(periph), .periph_in(periph_in), .pin_in(pin_in), .pin_out(pin_out),
      .pin_oe(pin_oe), .port_read(port_read), .pin_signal(pin_signal));
   pcx_pin_model u_pins (
      .pin_out(pin_out), .pin_oe(pin_oe), .ext_level(ext_level), .pin_in(pin_in));

   // ************************************************************
   // Reference decoder
   // ************************************************************
   function automatic logic [PCX_NUM_PINS-1:0][PCX_SIG_W-1:0] route(input pcx_cfg_t c);
      logic [PCX_NUM_PINS-1:0][PCX_SIG_W-1:0] m;
      logic [PCX_NUM_PINS-1:0]                taken;
      logic [PCX_NUM_SIG-1:0]                 en;
      logic [7:0]                             ra;
      int                                     p;
      m = '1;
      ra = c.route_select_a;
      taken = {c.port2_skip_mask, c.port1_skip_mask, c.port0_skip_mask};
      if (!c.route_select_b[RB_XBAR_EN])
         return m;
      if (ra[RA_UART])
      begin
         m[PCX_TX_PIN] = SIG_TX;
         m[PCX_RX_PIN] = SIG_RX;
         taken[PCX_RX_PIN:PCX_TX_PIN] = 2'h3;
      end
      en = '0;
      en[4:2] = {3{ra[RA_SPI]}};
      en[5] = ra[RA_SPI] && (c.spi_select_mode_field != PCX_SEL_3WIRE);
      en[7:6] = {2{ra[RA_SMB]}};
      en[12:8] = {ra[RA_SYSCK], ra[RA_CP1A], ra[RA_CP1], ra[RA_CMP0A], ra[RA_CP0]};
      for (int k = 0; k < 5; k++)
         en[13+k] = (c.route_select_b[2:0] <= PCX_CEX_MAX) && (k < c.route_select_b[2:0]);
      en[20:18] = c.route_select_b[RB_T1:RB_EXTC];
      p = 0;
      // Lowest free pin per enabled signal, in priority order
      for (int s = 2; s < PCX_NUM_SIG; s++)
      begin
         if (en[s])
         begin
            while (p < PCX_NUM_PINS && taken[p])
               p++;
            if (p < PCX_NUM_PINS)
            begin
               m[p] = 5'(s);
               taken[p] = 1'b1;
            end
         end
      end
      return m;
   endfunction : route

   function automatic pcx_cfg_t mk(input logic [7:0] ra, input logic [7:0] rb,
                                   input logic [7:0] s0, input logic [7:0] s1,
                                   input logic [3:0] s2, input logic [1:0] md);
      pcx_cfg_t c;
      c = {ra, rb, s0, s1, s2, 20'($urandom), md};
      return c;
   endfunction : mk

   // ************************************************************
   // Driver and checks
   // ************************************************************
   task automatic check(input logic [127:0] seen, input logic [127:0] exp);
      checked++;
      if (seen !== exp)
      begin
         errors++;
         $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic reset_dut();
      pcx_exp_t e;
      e = '0;
      e.sig = '1;
      e.per = '1;
      e.due = 32'(cyc + 1);
      rstn <= 1'b0;
      q.push_back(e);
      prev = e;
      repeat (3) @(posedge clk);
      rstn <= 1'b1;
   endtask : reset_dut

   // Holds one setting for two edges so the pins settle before the second
   task automatic apply(input pcx_cfg_t c, input logic ce_v);
      pcx_exp_t                e;
      logic [PCX_SIG_W-1:0]    s;
      logic                    o, d, pp;
      logic [PCX_NUM_PINS-1:0] snap;
      cfg <= c;
      ce <= ce_v;
      port_latch <= 20'($urandom);
      ext_level <= 20'($urandom);
      periph <= {21'($urandom), 21'($urandom) & ~21'h1C0002}; // Inputs never drive
      @(posedge clk);
      #1;
      snap = pin_in;
      e.sig = route(cfg);
      e.per = '1;
      for (int i = 0; i < PCX_NUM_PINS; i++)
      begin
         s = e.sig[i];
         o = (s == SIG_NONE) ? port_latch[i] : periph.out[s];
         d = (s == SIG_NONE) ? 1'b1 : periph.drive[s];
         pp = (cfg.port_output_mode[i] == PCX_MODE_PP) && (s != SIG_SDA) && (s != SIG_SCL);
         e.oe[i] = cfg.route_select_b[RB_XBAR_EN] && d && (pp || !o);
         e.out[i] = o;
         if (s != SIG_NONE)
            e.per[s] = snap[i];
      end
      e.rd = snap;
      if (!ce_v)
         e = prev;
      e.due = 32'(cyc + 1);
      q.push_back(e);
      prev = e;
      @(posedge clk);
   endtask : apply

   task automatic conclude();
      $display("errors %0d checked %0d", errors, checked);
      if (errors == 0 && checked > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : conclude

   // ************************************************************
   // Clock, watchdog and monitor
   // ************************************************************
   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // Cuts a hang short well past the expected run length
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == LIMIT)
      begin
         errors++;
         conclude();
      end
   end

   // Oldest note is compared once its result is due
   always @(negedge clk)
   begin
      if (q.size() > 0 && cyc >= int'(q[0].due))
      begin
         pcx_exp_t e;
         e = q.pop_front();
         check(128'(pin_signal), 128'(e.sig));
         check(128'(pin_oe), 128'(e.oe));
         check(128'(pin_out & pin_oe), 128'(e.out & e.oe));
         check(128'(periph_in), 128'(e.per));
         check(128'(port_read), 128'(e.rd));
      end
   end

   // ************************************************************
   // Scenarios
   // ************************************************************
   initial
   begin
      pcx_cfg_t c;
      void'($urandom(32'h186B8465));
      rstn = 1'b0;
      ce = 1'b0;  // Enable low across the release edge so no check starts there
      cfg = '0;
      port_latch = '1;
      periph = '0;
      ext_level = '0;
      errors = 0;
      checked = 0;
      cyc = 0;
      reset_dut();
      apply(mk(8'hFF, 8'h3D, 8'h00, 8'h00, 4'h0, 2'h1), 1'b1);
      apply(mk(8'h02, 8'h40, 8'h00, 8'h00, 4'h0, PCX_SEL_3WIRE), 1'b1);
      apply(mk(8'h02, 8'h40, 8'h00, 8'h00, 4'h0, 2'h1), 1'b1);
      apply(mk(8'h07, 8'h40, 8'h0C, 8'h00, 4'h0, 2'h2), 1'b1);
      apply(mk(8'h05, 8'h40, 8'h30, 8'h00, 4'h0, 2'h0), 1'b1);
      apply(mk(8'h04, 8'h40, 8'hCC, 8'h00, 4'h0, 2'h0), 1'b1);
      for (int k = 0; k < 8; k++)
         apply(mk(8'h00, 8'h40 | 8'(k), 8'h01, 8'h00, 4'h0, 2'h0), 1'b1);
      apply(mk(8'hFF, 8'h7D, 8'h00, 8'h00, 4'h0, 2'h1), 1'b1);
      apply(mk(8'hFF, 8'h7D, 8'hFF, 8'hFF, 4'hE, 2'h1), 1'b1);
      apply(mk(8'h02, 8'h40, 8'h00, 8'hFF, 4'h0, 2'h0), 1'b0);
      for (int n = 0; n < 150; n++)
      begin
         c = mk(8'($urandom), 8'($urandom), 8'($urandom), 8'($urandom),
                4'($urandom), 2'($urandom));
         c.route_select_b[RB_XBAR_EN] = ($urandom % 8) != 0;
         apply(c, ($urandom % 10) != 0);
         // Let the pending note be compared before reset wipes the outputs
         if (n == 75)
         begin
            @(posedge clk);
            ce <= 1'b0;
            reset_dut();
         end
      end
      repeat (3) @(posedge clk);
      conclude();
   end
endmodule : priority_pin_crossbar_test
